// [core/cllu_pkg.sv]
/*
 * Package for the table input-select and truth-table block.
 * Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
 */
package cllu_pkg;
    // ==========================================================
    // Register indexes (printed offsets; byte address = 4 * index)
    localparam logic [7:0] IDX_LUT0_SRC_SEL_IN0_IN1 = 8'h06;
    localparam logic [7:0] IDX_LUT0_SRC_SEL_IN2     = 8'h07;
    localparam logic [7:0] IDX_LUT0_OUTPUT_TABLE    = 8'h08;
    localparam logic [7:0] IDX_LUT1_SRC_SEL_IN0_IN1 = 8'h0a;
    localparam logic [7:0] IDX_LUT1_SRC_SEL_IN2     = 8'h0b;
    localparam logic [7:0] IDX_LUT1_OUTPUT_TABLE    = 8'h0c;
    localparam logic [7:0] IDX_TABLE_STRIDE         = 8'h04;
    // Own control register: enable bits and clock-origin bits
    localparam logic [7:0] IDX_TABLE_CONTROL        = 8'h10;
    localparam logic [7:0] IDX_TABLE_STATUS         = 8'h11;
    // ==========================================================
    // Field positions and reset values
    localparam int          CTL_ENABLE_POS   = 0;
    localparam int          CTL_CLKORG_POS   = 4;
    localparam int          SEL_HIGH_POS     = 4;
    localparam logic [7:0]  REG_RESET        = 8'h00;
    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_SLVERR      = 2'b10;
    // ==========================================================
    // Source selector codes
    localparam logic [3:0] SRC_MASK     = 4'h0;
    localparam logic [3:0] SRC_FEEDBACK = 4'h1;
    localparam logic [3:0] SRC_LINK     = 4'h2;
    localparam logic [3:0] SRC_EVENT0   = 4'h3;
    localparam logic [3:0] SRC_EVENT1   = 4'h4;
    localparam logic [3:0] SRC_IO       = 4'h5;
    localparam logic [3:0] SRC_COMP     = 4'h6;
    localparam logic [3:0] SRC_CAPT     = 4'h7;
    localparam logic [3:0] SRC_TIMA     = 4'h8;
    localparam logic [3:0] SRC_CTLT     = 4'h9;
    localparam logic [3:0] SRC_USART    = 4'ha;
    localparam logic [3:0] SRC_SPI      = 4'hb;

    // Per-input peripheral sources for one input index
    typedef struct packed {
        logic io_pin;
        logic timer_a_waveform;
        logic control_timer_waveform;
        logic usart_sig;
        logic spi_sig;
    } cllu_src_t;

    // Per-table configuration
    typedef struct packed {
        logic [3:0] input_zero_source;
        logic [3:0] input_one_source;
        logic [3:0] input_two_source;
        logic [7:0] output_table_bits;
        logic       table_clock_origin;
    } cllu_cfg_t;
endpackage

// [core/cllu_table_eval.sv]
/*
 * One three-input table: source muxing and truth-table lookup.
 * Assumes all sources are synchronous to aclk; output is registered.
 */
`timescale 1ns/100ps
`default_nettype none
module cllu_table_eval
    import cllu_pkg::*;
(
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Configuration
    input  wire cllu_cfg_t        cfg,
    input  wire logic             enable,
    // Shared sources
    input  wire logic             feedback,
    input  wire logic             link,
    input  wire logic [1:0]       event_in,
    input  wire logic             comparator_output,
    input  wire logic             capture_timer_waveform,
    input  wire logic             spi_valid,
    input  wire logic             usart_valid,
    input  wire cllu_src_t [2:0]  src,
    // Result
    output var  logic [2:0]       table_input_vector,
    output var  logic             table_out
);
    // ==========================================================
    // Source selection
    logic [2:0] sel_vec;
    logic [3:0] code [3];

    assign code[0] = cfg.input_zero_source;
    assign code[1] = cfg.input_one_source;
    assign code[2] = cfg.input_two_source;

    // One mux per input; invalid or reserved picks read low
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_in
            always_comb
            begin
                case (code[gi])
                    SRC_MASK:     sel_vec[gi] = 1'b0;
                    SRC_FEEDBACK: sel_vec[gi] = feedback;
                    SRC_LINK:     sel_vec[gi] = link;
                    SRC_EVENT0:   sel_vec[gi] = event_in[0];
                    SRC_EVENT1:   sel_vec[gi] = event_in[1];
                    SRC_IO:       sel_vec[gi] = src[gi].io_pin;
                    SRC_COMP:     sel_vec[gi] = comparator_output;
                    SRC_CAPT:     sel_vec[gi] = capture_timer_waveform;
                    SRC_TIMA:     sel_vec[gi] = src[gi].timer_a_waveform;
                    SRC_CTLT:     sel_vec[gi] = src[gi].control_timer_waveform;
                    // Input two has no USART source
                    SRC_USART:    sel_vec[gi] = (gi != 2) && usart_valid && src[gi].usart_sig;
                    SRC_SPI:      sel_vec[gi] = spi_valid && src[gi].spi_sig;
                    default:      sel_vec[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    // Input two forced low when it clocks the table
    logic [2:0] idx;
    assign idx = {sel_vec[2] & ~cfg.table_clock_origin, sel_vec[1:0]};

    // ==========================================================
    // Registered lookup, held low while disabled
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            table_out          <= 1'b0;
            table_input_vector <= 3'b000;
        end
        else
        begin
            table_input_vector <= idx;
            table_out          <= enable & cfg.output_table_bits[idx];
        end
    end

    // Lookup is registered on the same edge as the index, one cycle after idx
    property p_lookup;
        @(posedge aclk) disable iff (!aresetn)
        enable |=> table_out == cfg.output_table_bits[$past(idx)] || $changed(cfg);
    endproperty
    a_lookup: assert property (p_lookup) else $error("table output mismatch");

    property p_clk_origin;
        @(posedge aclk) disable iff (!aresetn)
        cfg.table_clock_origin |=> !table_input_vector[2] || $changed(cfg);
    endproperty
    a_clk_origin: assert property (p_clk_origin) else $error("input two not forced low");

    property p_mask;
        @(posedge aclk) disable iff (!aresetn)
        code[0] == SRC_MASK |=> !table_input_vector[0] || $changed(cfg);
    endproperty
    a_mask: assert property (p_mask) else $error("masked input not low");

    property p_spi;
        @(posedge aclk) disable iff (!aresetn)
        (code[1] == SRC_SPI && !spi_valid) |=> !table_input_vector[1] || $changed(cfg);
    endproperty
    a_spi: assert property (p_spi) else $error("spi input while client");

    property p_usart;
        @(posedge aclk) disable iff (!aresetn)
        (code[0] == SRC_USART && !usart_valid) |=> !table_input_vector[0] || $changed(cfg);
    endproperty
    a_usart: assert property (p_usart) else $error("usart input in bad mode");

    property p_in2_usart_rsv;
        @(posedge aclk) disable iff (!aresetn)
        code[2] == SRC_USART |=> !table_input_vector[2] || $changed(cfg);
    endproperty
    a_in2_usart_rsv: assert property (p_in2_usart_rsv) else $error("reserved code drives input two");

    property p_comp;
        @(posedge aclk) disable iff (!aresetn)
        (code[1] == SRC_COMP && comparator_output) |=> table_input_vector[1] || $changed(cfg);
    endproperty
    a_comp: assert property (p_comp) else $error("comparator not routed");
endmodule
`default_nettype wire

// [core/cllu_top.sv]
/*
 * Configurable logic unit: input selection and truth tables for two tables,
 * with an AXI4-Lite register slave.
 * Assumes all peripheral sources are synchronous to aclk.
 */
`timescale 1ns/100ps
`default_nettype none
module cllu_top
    import cllu_pkg::*;
(
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // AXI4-Lite write address
    input  wire logic [31:0]  s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output var  logic         s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output var  logic         s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]   s_axi_bresp,
    output var  logic         s_axi_bvalid,
    input  wire logic         s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0]  s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output var  logic         s_axi_arready,
    // AXI4-Lite read data
    output var  logic [31:0]  s_axi_rdata,
    output var  logic [1:0]   s_axi_rresp,
    output var  logic         s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // Shared sources
    input  wire logic [1:0]   event_in,
    input  wire logic         comparator_output,
    input  wire logic         capture_timer_waveform,
    input  wire logic         spi_host_mode,
    input  wire logic         usart_mode_ok,
    // Per-table, per-input sources
    input  wire cllu_src_t [2:0] lut0_src,
    input  wire cllu_src_t [2:0] lut1_src,
    // Table outputs
    output var  logic [1:0]   table_out
);
    // ==========================================================
    // Register storage
    cllu_cfg_t  cfg_reg [2];
    logic [1:0] enable_reg;
    logic [1:0] clkorg_reg;

    // ==========================================================
    // Write channel: address and data latched in either order
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [31:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        do_write;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

    // Capture halves as they arrive
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 32'h0000_0000;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            else if (do_write)
            begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            else if (do_write)
            begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Address decode of the held write
    logic [7:0] widx;
    logic       wmapped;
    logic       wtable;
    logic [1:0] wkind;
    assign widx = awaddr_reg[9:2];

    always_comb
    begin
        wmapped = 1'b1;
        wtable  = 1'b0;
        wkind   = 2'd0;
        if (widx == IDX_LUT0_SRC_SEL_IN0_IN1)
            wkind = 2'd0;
        else if (widx == IDX_LUT0_SRC_SEL_IN2)
            wkind = 2'd1;
        else if (widx == IDX_LUT0_OUTPUT_TABLE)
            wkind = 2'd2;
        else if (widx == IDX_LUT1_SRC_SEL_IN0_IN1)
        begin
            wtable = 1'b1;
            wkind  = 2'd0;
        end
        else if (widx == IDX_LUT1_SRC_SEL_IN2)
        begin
            wtable = 1'b1;
            wkind  = 2'd1;
        end
        else if (widx == IDX_LUT1_OUTPUT_TABLE)
        begin
            wtable = 1'b1;
            wkind  = 2'd2;
        end
        else if (widx == IDX_TABLE_CONTROL)
            wkind = 2'd3;
        else if (widx == IDX_TABLE_STATUS)
            wmapped = 1'b0;
        else
            wmapped = 1'b0;
    end

    // Table registers; locked while the table runs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int t = 0; t < 2; t++)
            begin
                cfg_reg[t].input_zero_source <= REG_RESET[3:0];
                cfg_reg[t].input_one_source  <= REG_RESET[3:0];
                cfg_reg[t].input_two_source  <= REG_RESET[3:0];
                cfg_reg[t].output_table_bits <= REG_RESET;
                cfg_reg[t].table_clock_origin <= 1'b0;
            end
        end
        else if (do_write && wmapped && wkind != 2'd3 && wstrb_reg[0] && !enable_reg[wtable])
        begin
            case (wkind)
                2'd0:
                begin
                    cfg_reg[wtable].input_zero_source <= wdata_reg[3:0];
                    cfg_reg[wtable].input_one_source  <= wdata_reg[SEL_HIGH_POS +: 4];
                end
                2'd1:    cfg_reg[wtable].input_two_source  <= wdata_reg[3:0];
                default: cfg_reg[wtable].output_table_bits <= wdata_reg[7:0];
            endcase
        end
    end

    // Control register: enables and clock-origin bits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_reg <= 2'b00;
            clkorg_reg <= 2'b00;
        end
        else if (do_write && wmapped && wkind == 2'd3 && wstrb_reg[0])
        begin
            enable_reg <= wdata_reg[CTL_ENABLE_POS +: 2];
            clkorg_reg <= wdata_reg[CTL_CLKORG_POS +: 2];
        end
    end

    // Write response; a locked write still answers OKAY
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wmapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Read channel: one-cycle answer from registers
    logic [7:0]  ridx;
    logic [31:0] rword;
    logic        rmapped;
    assign ridx          = s_axi_araddr[9:2];
    assign s_axi_arready = !s_axi_rvalid;

    always_comb
    begin
        rword   = 32'h0000_0000;
        rmapped = 1'b1;
        if (ridx == IDX_LUT0_SRC_SEL_IN0_IN1)
            rword[7:0] = {cfg_reg[0].input_one_source, cfg_reg[0].input_zero_source};
        else if (ridx == IDX_LUT0_SRC_SEL_IN2)
            rword[3:0] = cfg_reg[0].input_two_source;
        else if (ridx == IDX_LUT0_OUTPUT_TABLE)
            rword[7:0] = cfg_reg[0].output_table_bits;
        else if (ridx == IDX_LUT0_SRC_SEL_IN0_IN1 + IDX_TABLE_STRIDE)
            rword[7:0] = {cfg_reg[1].input_one_source, cfg_reg[1].input_zero_source};
        else if (ridx == IDX_LUT1_SRC_SEL_IN2)
            rword[3:0] = cfg_reg[1].input_two_source;
        else if (ridx == IDX_LUT1_OUTPUT_TABLE)
            rword[7:0] = cfg_reg[1].output_table_bits;
        else if (ridx == IDX_TABLE_CONTROL)
        begin
            rword[CTL_ENABLE_POS +: 2] = enable_reg;
            rword[CTL_CLKORG_POS +: 2] = clkorg_reg;
        end
        else if (ridx == IDX_TABLE_STATUS)
            rword[1:0] = table_out;
        else
            rmapped = 1'b0;
    end

    // Read data register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rword;
            s_axi_rresp  <= rmapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Two tables; each links to the other, feeds back its own output
    cllu_cfg_t cfg_full [2];
    genvar gt;
    generate
        for (gt = 0; gt < 2; gt++)
        begin : g_tab
            always_comb
            begin
                cfg_full[gt]                    = cfg_reg[gt];
                cfg_full[gt].table_clock_origin = clkorg_reg[gt];
            end
            cllu_table_eval u_tab (
                .aclk                   (aclk),
                .aresetn                (aresetn),
                .cfg                    (cfg_full[gt]),
                .enable                 (enable_reg[gt]),
                .feedback               (table_out[gt]),
                .link                   (table_out[1 - gt]),
                .event_in               (event_in),
                .comparator_output      (comparator_output),
                .capture_timer_waveform (capture_timer_waveform),
                .spi_valid              (spi_host_mode),
                .usart_valid            (usart_mode_ok),
                .src                    (gt == 0 ? lut0_src : lut1_src),
                .table_input_vector     (),
                .table_out              (table_out[gt])
            );
        end
    endgenerate

    // Locked table keeps its truth bits across a write
    property p_lock;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && widx == IDX_LUT0_OUTPUT_TABLE && enable_reg[0])
            |=> $stable(cfg_reg[0].output_table_bits);
    endproperty
    a_lock: assert property (p_lock) else $error("write to enabled table taken");

    sequence s_wr_ok;
        do_write && widx == IDX_LUT1_OUTPUT_TABLE && !enable_reg[1] && wstrb_reg[0];
    endsequence
    property p_wr_take;
        @(posedge aclk) disable iff (!aresetn)
        s_wr_ok |=> cfg_reg[1].output_table_bits == $past(wdata_reg[7:0]) ##0 s_axi_bvalid;
    endproperty
    a_wr_take: assert property (p_wr_take) else $error("write to disabled table lost");

    // Reset clears table registers; no disable on purpose
    property p_reset_clear;
        @(posedge aclk)
        !aresetn |=> enable_reg == 2'b00 && clkorg_reg == 2'b00
            && cfg_reg[0].output_table_bits == REG_RESET && cfg_reg[1].output_table_bits == REG_RESET;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("register not cleared");

    property p_lock_sel;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && widx == IDX_LUT0_SRC_SEL_IN0_IN1 && enable_reg[0])
            |=> $stable(cfg_reg[0].input_zero_source) && $stable(cfg_reg[0].input_one_source);
    endproperty
    a_lock_sel: assert property (p_lock_sel) else $error("select write taken");

    // Pending response blocks both write halves
    property p_one_write;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_one_write: assert property (p_one_write) else $error("write taken early");

    property p_ctl_take;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && widx == IDX_TABLE_CONTROL && wstrb_reg[0])
            |=> enable_reg == $past(wdata_reg[CTL_ENABLE_POS +: 2])
            && clkorg_reg == $past(wdata_reg[CTL_CLKORG_POS +: 2]);
    endproperty
    a_ctl_take: assert property (p_ctl_take) else $error("control write lost");
endmodule
`default_nettype wire

// [tb/cllu_far_side.sv]
/*
 * Far-side model: peripheral, event and pin levels feeding the tables.
 * Assumes the bench steers it by a source mask and an input index.
 */
`timescale 1ns/100ps
`default_nettype none
module cllu_far_side
    import cllu_pkg::*;
(
    // Steering from the bench
    input  wire logic [15:0]     on,
    input  wire logic [2:0]      on_idx,
    input  wire logic            modes_ok,
    // Levels into the block
    output var  logic [1:0]      event_in,
    output var  logic            comparator_output,
    output var  logic            capture_timer_waveform,
    output var  logic            spi_host_mode,
    output var  logic            usart_mode_ok,
    output var  cllu_src_t [2:0] src
);
    // ==========================================================
    // Bit n of on raises the source that selector code n picks
    always_comb
    begin
        event_in               = on[4:3];
        comparator_output      = on[6];
        capture_timer_waveform = on[7];
        spi_host_mode          = modes_ok; // Low stands for client-mode SPI
        usart_mode_ok          = modes_ok;
        // Per-index sources only on the index under test, to catch crossed wiring
        for (int i = 0; i < 3; i++)
            src[i] = {on[5], on[8], on[9], on[10], on[11]} & {5{on_idx[i]}};
    end
endmodule
`default_nettype wire

// [tb/tb.sv]
/*
 * Self-checking bench for cllu_top over AXI4-Lite.
 * Assumes the far-side model cllu_far_side.
 */
`timescale 1ns/100ps
`default_nettype none
module tb
    import cllu_pkg::*;
;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, comp, capt, spi_ok, usart_ok;
    logic [1:0]  bresp, rresp, table_out, last_resp, event_in;
    logic [3:0]  wstrb = 4'hf;
    logic [15:0] on = '0;
    logic [2:0]  on_idx = '0;
    logic        modes_ok = 1'b1;
    cllu_src_t [2:0] src;
    int          bad_count = 0, checked = 0;

    // ==========================================================
    // Clock, block and far side
    always #20 aclk = ~aclk;
    cllu_top cllu_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_in(event_in),
        .comparator_output(comp), .capture_timer_waveform(capt), .spi_host_mode(spi_ok),
        .usart_mode_ok(usart_ok), .lut0_src(src), .lut1_src(src), .table_out(table_out));
    cllu_far_side cllu_far_side_i (.on(on), .on_idx(on_idx), .modes_ok(modes_ok), .event_in(event_in),
        .comparator_output(comp), .capture_timer_waveform(capt), .spi_host_mode(spi_ok),
        .usart_mode_ok(usart_ok), .src(src));

    // ==========================================================
    // Shared helpers
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    function automatic logic [31:0] ba(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction

    // Ready is sampled just after the edge; it only moves on edges
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic ah, wh, bh;
        int n;
        n = 0;
        @(posedge aclk);
        awaddr  <= ba(idx);
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            #1;
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bvalid;
            last_resp = bresp;
            @(posedge aclk);
            if (ah)
                awvalid <= 1'b0;
            if (wh)
                wvalid <= 1'b0;
            n++;
        end while (!bh && n < 100);
        bready <= 1'b0;
        chk("write answer", 32'h1, {31'h0, bh});
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        logic ah, bh;
        int n;
        n = 0;
        @(posedge aclk);
        araddr  <= ba(idx);
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            #1;
            ah = arvalid & arready;
            bh = rvalid;
            d = rdata;
            last_resp = rresp;
            @(posedge aclk);
            if (ah)
                arvalid <= 1'b0;
            n++;
        end while (!bh && n < 100);
        rready <= 1'b0;
        chk("read answer", 32'h1, {31'h0, bh});
    endtask

    // Output is registered, so give the levels a few edges to land
    task automatic drive(input logic [15:0] o, input logic [2:0] ix, input logic m);
        @(posedge aclk);
        on       <= o;
        on_idx   <= ix;
        modes_ok <= m;
        repeat (3) @(posedge aclk);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs;
        logic [7:0]  ix [7] = '{IDX_LUT0_SRC_SEL_IN0_IN1, IDX_LUT0_SRC_SEL_IN2, IDX_LUT0_OUTPUT_TABLE,
            IDX_LUT1_SRC_SEL_IN0_IN1, IDX_LUT1_SRC_SEL_IN2, IDX_LUT1_OUTPUT_TABLE, IDX_TABLE_CONTROL};
        logic [31:0] d;
        foreach (ix[k])
        begin
            rd(ix[k], d);
            chk("reset value", 32'h0, d);
        end
        rd(8'h09, d);
        chk("unmapped resp", RESP_SLVERR, last_resp);
        wr(IDX_LUT0_OUTPUT_TABLE, 32'ha5);
        wr(IDX_LUT0_OUTPUT_TABLE + IDX_TABLE_STRIDE, 32'h5a);
        rd(IDX_LUT0_OUTPUT_TABLE, d);
        chk("lut0_output_table", 32'ha5, d);
        rd(IDX_LUT1_OUTPUT_TABLE, d);
        chk("lut1_output_table", 32'h5a, d);
    endtask

    // Every listed code on every input except USART on input two; only the chosen source may show
    task automatic t_sweep;
        logic [7:0] tt [3] = '{8'haa, 8'hcc, 8'hf0};
        logic       e;
        for (int i = 0; i < 3; i++)
            for (int c = 0; c < 12; c++)
            begin
                if (i == 2 && c == 10)
                    continue;
                wr(IDX_TABLE_CONTROL, 32'h0);
                wr(IDX_LUT0_SRC_SEL_IN0_IN1, i == 0 ? c : (i == 1 ? c << 4 : 0));
                wr(IDX_LUT0_SRC_SEL_IN2, i == 2 ? c : 0);
                wr(IDX_LUT0_OUTPUT_TABLE, tt[i]);
                wr(IDX_TABLE_CONTROL, 32'h1);
                for (int m = 0; m < 2; m++)
                    for (int s = 3; s < 12; s++)
                    begin
                        drive(16'h1 << s, 3'h1 << i, m[0]);
                        e = (s == c) && (m == 1 || c < 10) && !(i == 2 && c == 10);
                        chk("selected source", e, table_out[0]);
                    end
            end
        drive(16'h0, 3'h0, 1'b1);
    endtask

    task automatic t_truth;
        logic [31:0] d;
        wr(IDX_TABLE_CONTROL, 32'h0);
        wr(IDX_LUT0_SRC_SEL_IN0_IN1, 32'h43);
        wr(IDX_LUT0_SRC_SEL_IN2, 32'h06);
        wr(IDX_LUT0_OUTPUT_TABLE, 32'h96);
        for (int k = 0; k < 2; k++)
        begin
            wr(IDX_TABLE_CONTROL, k ? 32'h11 : 32'h1);
            for (int v = 0; v < 8; v++)
            begin
                drive({9'h0, v[2], 1'b0, v[1:0], 3'h0}, 3'h0, 1'b1);
                chk("truth lookup", 8'h96 >> (k ? v % 4 : v) & 1, table_out[0]);
            end
        end
        // Enabled table must keep its settings
        wr(IDX_TABLE_CONTROL, 32'h1);
        wr(IDX_LUT0_OUTPUT_TABLE, 32'hff);
        chk("protected write resp", RESP_OKAY, last_resp);
        wr(IDX_LUT0_SRC_SEL_IN0_IN1, 32'h0);
        rd(IDX_LUT0_OUTPUT_TABLE, d);
        chk("protected truth", 32'h96, d);
        rd(IDX_LUT0_SRC_SEL_IN0_IN1, d);
        chk("protected select", 32'h43, d);
    endtask

    task automatic t_link;
        logic [31:0] d;
        wr(IDX_TABLE_CONTROL, 32'h0);
        wr(IDX_LUT1_OUTPUT_TABLE, 32'hff);
        wr(IDX_LUT0_SRC_SEL_IN0_IN1, SRC_LINK);
        wr(IDX_LUT0_SRC_SEL_IN2, 32'h0);
        wr(IDX_LUT0_OUTPUT_TABLE, 32'haa);
        wr(IDX_TABLE_CONTROL, 32'h3);
        drive(16'h0, 3'h0, 1'b1);
        chk("linked outputs", 2'b11, table_out);
        rd(IDX_TABLE_STATUS, d);
        chk("status", 32'h3, d);
    endtask

    // ==========================================================
    // Verdict, main sequence and watchdog
    task give_verdict;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_sweep;
        t_truth;
        t_link;
        give_verdict;
    end

    // Whole run is near 3400 cycles; a hang stops well past that
    initial
    begin
        #1_000_000;
        bad_count++;
        give_verdict;
    end
endmodule
`default_nettype wire
